// *** core/sram_cmd_pkg.sv ***
package sram_cmd_pkg;

    // ********************************************************************
    // geometry
    // ********************************************************************
    localparam int LANES = 8;
    localparam int LANE_DATA_W = 8;
    localparam int ADDR_W = 19;
    localparam int BURST_W = 2;

    // ********************************************************************
    // reset values
    // ********************************************************************
    localparam logic RESET_VALID = 1'h0;
    localparam logic RESET_WRITE = 1'h0;
    localparam logic RESET_OE = 1'h0;
    localparam logic [LANES-1:0] RESET_SEL_N = 8'hFF;

    // ********************************************************************
    // cycle kind codes for stage two
    // ********************************************************************
    typedef enum logic [1:0] {
        CYC_IDLE,
        CYC_READ,
        CYC_WRITE
    } cycle_kind_e;

endpackage : sram_cmd_pkg

// *** core/burst_ctrl_if.sv ***
`timescale 1ns/100ps
interface burst_ctrl_if #(
    parameter int ADDR_W = sram_cmd_pkg::ADDR_W
);
    logic load;
    logic advance;
    logic [ADDR_W-1:0] load_addr;
    logic [ADDR_W-1:0] addr;

    modport owner (
        output load,
        output advance,
        output load_addr,
        input addr
    );

    modport counter (
        input load,
        input advance,
        input load_addr,
        output addr
    );
endinterface : burst_ctrl_if

// *** core/burst_addr_counter.sv ***
`timescale 1ns/100ps
module burst_addr_counter #(
    parameter int ADDR_W = sram_cmd_pkg::ADDR_W
) (
    input wire logic clk_sys,
    input wire logic reset,
    burst_ctrl_if.counter ctl
);
    localparam int BW = sram_cmd_pkg::BURST_W;

    if (ADDR_W <= BW)
    begin : g_bad_addr_w
        $error("ADDR_W must lie above the burst width");
    end

    logic [ADDR_W-1:0] addr;
    logic [BW-1:0] next_low;
    logic [ADDR_W-1:0] next_addr;

    // ********************************************************************
    // burst step
    // ********************************************************************
    // only the low bits step, so a burst wraps inside its aligned group
    assign next_low = addr[BW-1:0] + {{(BW-1){1'b0}}, 1'b1};
    assign next_addr = ctl.load ? ctl.load_addr :
        ctl.advance ? {addr[ADDR_W-1:BW], next_low} : addr;
    assign ctl.addr = addr;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            addr <= '0;
        else
            addr <= next_addr;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_burst_wrap_step: assert property (
        ctl.advance && !ctl.load |=>
            addr[ADDR_W-1:BW] == $past(addr[ADDR_W-1:BW]) &&
            addr[BW-1:0] == BW'($past(addr[BW-1:0]) + 1))
        else $error("burst counter did not step within its group");

endmodule : burst_addr_counter

// *** core/sync_burst_sram_cmd_port.sv ***
`timescale 1ns/100ps
module sync_burst_sram_cmd_port #(
    parameter int ADDR_W = sram_cmd_pkg::ADDR_W
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] address,
    input wire logic write_strobe_n,
    input wire logic advance_or_load,
    input wire logic clock_qualify_n,
    input wire logic chip_select_first_n,
    input wire logic chip_select_second,
    input wire logic chip_select_third_n,
    input wire logic lane_a_write_select_n,
    input wire logic lane_b_write_select_n,
    input wire logic lane_c_write_select_n,
    input wire logic lane_d_write_select_n,
    input wire logic lane_e_write_select_n,
    input wire logic lane_f_write_select_n,
    input wire logic lane_g_write_select_n,
    input wire logic lane_h_write_select_n,
    input wire logic [63:0] byte_lane_data_in,
    output logic [63:0] byte_lane_data_out,
    output logic byte_lane_data_oe,
    input wire logic [7:0] byte_lane_parity_in,
    output logic [7:0] byte_lane_parity_out,
    output logic byte_lane_parity_oe
);
    localparam int LANES = sram_cmd_pkg::LANES;
    localparam int DW = sram_cmd_pkg::LANE_DATA_W;
    localparam int DEPTH = 2 ** ADDR_W;

    if (ADDR_W <= sram_cmd_pkg::BURST_W || ADDR_W > 20)
    begin : g_bad_addr_w
        $error("ADDR_W must lie above the burst width and at most 20");
    end

    // ********************************************************************
    // command decode
    // ********************************************************************
    logic [LANES-1:0] lane_sel_n;
    wire qualified = !clock_qualify_n;
    wire selected = !chip_select_first_n && chip_select_second &&
        !chip_select_third_n;
    wire load_cycle = qualified && !advance_or_load;
    wire advance_cycle = qualified && advance_or_load;

    assign lane_sel_n = {lane_h_write_select_n, lane_g_write_select_n,
        lane_f_write_select_n, lane_e_write_select_n,
        lane_d_write_select_n, lane_c_write_select_n,
        lane_b_write_select_n, lane_a_write_select_n};

    // ********************************************************************
    // stage one: command register
    // ********************************************************************
    logic s1_valid;
    logic s1_write;
    logic [LANES-1:0] s1_sel_n;
    // an advance carries on whatever the last load started, even a deselect
    wire next_s1_valid = load_cycle ? selected : s1_valid;
    wire next_s1_write = load_cycle ?
        (selected && !write_strobe_n) : s1_write;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            s1_valid <= sram_cmd_pkg::RESET_VALID;
            s1_write <= sram_cmd_pkg::RESET_WRITE;
            s1_sel_n <= sram_cmd_pkg::RESET_SEL_N;
        end
        else if (qualified)
        begin
            s1_valid <= next_s1_valid;
            s1_write <= next_s1_write;
            s1_sel_n <= lane_sel_n;
        end
    end

    // ********************************************************************
    // burst address counter
    // ********************************************************************
    burst_ctrl_if #(.ADDR_W(ADDR_W)) ctl ();

    assign ctl.load = load_cycle;
    assign ctl.advance = advance_cycle;
    assign ctl.load_addr = address;

    burst_addr_counter #(.ADDR_W(ADDR_W)) u_counter (
        .clk_sys(clk_sys),
        .reset(reset),
        .ctl(ctl)
    );

    // ********************************************************************
    // stage two: data phase
    // ********************************************************************
    logic s2_valid;
    logic s2_write;
    logic [LANES-1:0] s2_sel_n;
    logic [ADDR_W-1:0] s2_addr;
    sram_cmd_pkg::cycle_kind_e s2_kind;

    assign s2_kind = !s2_valid ? sram_cmd_pkg::CYC_IDLE :
        s2_write ? sram_cmd_pkg::CYC_WRITE : sram_cmd_pkg::CYC_READ;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            s2_valid <= sram_cmd_pkg::RESET_VALID;
            s2_write <= sram_cmd_pkg::RESET_WRITE;
            s2_sel_n <= sram_cmd_pkg::RESET_SEL_N;
            s2_addr <= '0;
        end
        else if (qualified)
        begin
            s2_valid <= s1_valid;
            s2_write <= s1_write;
            s2_sel_n <= s1_sel_n;
            s2_addr <= ctl.addr;
        end
    end

    // ********************************************************************
    // storage and data pins
    // ********************************************************************
    // no reset on the array: contents are undefined until written
    logic [LANES*DW-1:0] mem_data [0:DEPTH-1];
    logic [LANES-1:0] mem_par [0:DEPTH-1];
    logic [LANES-1:0] lane_we;
    logic drive;

    assign lane_we = {LANES{qualified && s2_kind == sram_cmd_pkg::CYC_WRITE}}
        & ~s2_sel_n;
    // pins stay off for write data and for deselect slots
    assign drive = s2_kind == sram_cmd_pkg::CYC_READ;

    always_ff @(posedge clk_sys)
    begin
        for (int i = 0; i < LANES; i++)
        begin
            if (lane_we[i])
            begin
                mem_data[s2_addr][i*DW +: DW] <=
                    byte_lane_data_in[i*DW +: DW];
                mem_par[s2_addr][i] <= byte_lane_parity_in[i];
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            byte_lane_data_oe <= sram_cmd_pkg::RESET_OE;
            byte_lane_parity_oe <= sram_cmd_pkg::RESET_OE;
            byte_lane_data_out <= '0;
            byte_lane_parity_out <= '0;
        end
        else if (qualified)
        begin
            byte_lane_data_oe <= drive;
            byte_lane_parity_oe <= drive;
            if (drive)
            begin
                byte_lane_data_out <= mem_data[s2_addr];
                byte_lane_parity_out <= mem_par[s2_addr];
            end
        end
    end

    // ********************************************************************
    // checks
    // ********************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_suspend_freezes: assert property (
        clock_qualify_n |=> $stable(s1_valid) && $stable(s2_valid) &&
            $stable(ctl.addr) && $stable(byte_lane_data_oe))
        else $error("state moved on a suspended edge");

    a_load_takes_addr: assert property (
        load_cycle |=> ctl.addr == $past(address))
        else $error("load did not capture the address pins");

    a_advance_keeps_op: assert property (
        advance_cycle |=> s1_valid == $past(s1_valid) &&
            ctl.addr != $past(ctl.addr))
        else $error("advance did not step the counter");

    a_select_needs_all: assert property (
        load_cycle && (chip_select_first_n || !chip_select_second ||
            chip_select_third_n) |=> !s1_valid)
        else $error("device selected without all three selects");

    a_write_strobe_taken: assert property (
        load_cycle && selected |=> s1_valid &&
            s1_write == !$past(write_strobe_n))
        else $error("write strobe not taken at a qualified load");

    a_write_floats_pins: assert property (
        load_cycle && selected && !write_strobe_n ##1 qualified ##1 qualified
            |=> !byte_lane_data_oe && !byte_lane_parity_oe)
        else $error("pins driven during write data");

    a_deselect_floats: assert property (
        load_cycle && !selected ##1 qualified ##1 qualified |=>
            !byte_lane_data_oe)
        else $error("pins driven while deselected");

    a_lane_select_mask: assert property (
        load_cycle && selected && !write_strobe_n ##1 qualified ##1 qualified
            |-> lane_we == ~$past(lane_sel_n, 2))
        else $error("lane write enables differ from the selects");

    a_data_captured: assert property (
        lane_we[0] |=> mem_data[$past(s2_addr)][DW-1:0] ==
            $past(byte_lane_data_in[DW-1:0]))
        else $error("write data lane zero not stored");

    c_write_then_read: cover property (
        load_cycle && selected && !write_strobe_n ##1 load_cycle &&
            selected && write_strobe_n);
    c_burst_advance: cover property (
        load_cycle && selected ##1 advance_cycle [*3]);
    c_suspend_in_read: cover property (
        s2_kind == sram_cmd_pkg::CYC_READ && clock_qualify_n);
    c_deselect: cover property (load_cycle && !selected);

endmodule : sync_burst_sram_cmd_port

// *** sim/controller_model.sv ***
`timescale 1ns/100ps
module controller_model #(
    parameter int ADDR_W = sram_cmd_pkg::ADDR_W
) (
    input wire logic clk_sys,
    output logic [ADDR_W-1:0] address,
    output logic write_strobe_n,
    output logic advance_or_load,
    output logic clock_qualify_n,
    output logic [2:0] chip_selects,
    output logic [7:0] lane_select_n,
    output logic [71:0] write_word
);
    // ****************************************************************
    // command driver with two-slot write data pipeline
    // ****************************************************************
    // write data trails its command by two qualified edges
    logic [71:0] slot1 = '0;
    logic [71:0] slot2 = '0;

    initial
    begin
        address = '0;
        write_strobe_n = 1'h1;
        advance_or_load = 1'h0;
        clock_qualify_n = 1'h1;
        chip_selects = 3'h5;
        lane_select_n = 8'hff;
        write_word = '0;
    end

    task automatic drive(
        input logic qn, input logic ad, input logic we, input logic [2:0] c,
        input logic [ADDR_W-1:0] a, input logic [7:0] sn,
        input logic [71:0] wd
    );
        @(posedge clk_sys);
        clock_qualify_n <= qn;
        advance_or_load <= ad;
        write_strobe_n <= we;
        chip_selects <= c;
        address <= a;
        lane_select_n <= sn;
        if (qn)
        begin
            // an ignored edge sees garbage, never the pending word
            write_word <= ~write_word;
        end
        else
        begin
            write_word <= slot2;
            slot2 = slot1;
            slot1 = wd;
        end
    endtask : drive
endmodule : controller_model

// *** sim/sync_burst_sram_cmd_port_tb.sv ***
`timescale 1ns/100ps
`define check(got, exp) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) \
        begin \
            $display("Error at %0t: got %h expected %h", $time, got, exp); \
            bad_count++; \
        end \
    end

module sync_burst_sram_cmd_port_tb;
    // ****************************************************************
    // signals and reference state
    // ****************************************************************
    localparam int AW = sram_cmd_pkg::ADDR_W;
    typedef struct { int idx; logic [71:0] val; } note_s;
    logic clk_sys = 1'h0;
    logic reset = 1'h1;
    logic [AW-1:0] address;
    logic we_n;
    logic adv;
    logic q_n;
    logic [2:0] cs;
    logic [7:0] sel_n;
    logic [71:0] word;
    logic [63:0] data_out;
    logic data_oe;
    logic [7:0] parity_out;
    logic parity_oe;
    logic [71:0] mem [int];
    note_s exp_q [$];
    note_s head;
    int bad_count = 0;
    int n_tests = 0;
    int qcount = 0;
    int cmd_q = 0;
    int seed = 32'h13f8_b3eb;
    logic sel = 1'h0;
    logic wr = 1'h0;
    logic [AW-1:0] cnt = '0;

    always #50 clk_sys = ~clk_sys;

    controller_model #(.ADDR_W(AW)) ctl (.clk_sys(clk_sys),
        .address(address), .write_strobe_n(we_n), .advance_or_load(adv),
        .clock_qualify_n(q_n), .chip_selects(cs), .lane_select_n(sel_n),
        .write_word(word));

    sync_burst_sram_cmd_port #(.ADDR_W(AW)) DUT (.clk_sys(clk_sys),
        .reset(reset), .address(address), .write_strobe_n(we_n),
        .advance_or_load(adv), .clock_qualify_n(q_n),
        .chip_select_first_n(cs[0]), .chip_select_second(cs[1]),
        .chip_select_third_n(cs[2]), .lane_a_write_select_n(sel_n[0]),
        .lane_b_write_select_n(sel_n[1]), .lane_c_write_select_n(sel_n[2]),
        .lane_d_write_select_n(sel_n[3]), .lane_e_write_select_n(sel_n[4]),
        .lane_f_write_select_n(sel_n[5]), .lane_g_write_select_n(sel_n[6]),
        .lane_h_write_select_n(sel_n[7]), .byte_lane_data_in(word[71:8]),
        .byte_lane_data_out(data_out), .byte_lane_data_oe(data_oe),
        .byte_lane_parity_in(word[7:0]), .byte_lane_parity_out(parity_out),
        .byte_lane_parity_oe(parity_oe));

    // ****************************************************************
    // driver and reference model
    // ****************************************************************
    task automatic cmd(
        input logic qn, input logic ad, input logic we, input logic [2:0] c,
        input logic [AW-1:0] a, input logic [7:0] sn
    );
        logic [71:0] wd;
        int i;
        wd = {$random(seed), $random(seed), 8'($random(seed))};
        ctl.drive(qn, ad, we, c, a, sn, wd);
        if (!qn)
        begin
            cmd_q++;
            if (!ad)
            begin
                sel = (c == 3'h2);
                wr = !we;
                cnt = a;
            end
            else
                cnt[1:0] = cnt[1:0] + 2'h1;
            for (i = 0; i < 8; i++)
                if (sel && wr && !sn[i])
                begin
                    mem[cnt][8 + 8 * i +: 8] = wd[8 + 8 * i +: 8];
                    mem[cnt][i] = wd[i];
                end
            if (sel && !wr)
                exp_q.push_back('{cmd_q + 3, mem[cnt]});
        end
    endtask : cmd

    // advance beats carry deasserted selects: they must be ignored
    task automatic burst(input logic [AW-1:0] a, input logic we);
        int i;
        cmd(1'h0, 1'h0, we, 3'h2, a, 8'h00);
        for (i = 0; i < 3; i++)
            cmd(1'h0, 1'h1, 1'h1, 3'h5, a, 8'h00);
    endtask : burst

    task automatic print_verdict();
        if (bad_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    // ****************************************************************
    // monitor: one note per read slot, on qualified edges only
    // ****************************************************************
    always @(posedge clk_sys)
    begin
        if (!reset && q_n === 1'h0)
        begin
            qcount++;
            `check(parity_oe, data_oe)
            if (data_oe === 1'h1)
            begin
                if (exp_q.size() == 0)
                    `check(data_oe, 1'h0)
                else
                begin
                    head = exp_q.pop_front();
                    `check(qcount, head.idx)
                    `check({data_out, parity_out}, head.val)
                end
            end
            else if (exp_q.size() > 0 && exp_q[0].idx == qcount)
                `check(data_oe, 1'h1)
        end
    end

    initial
    begin
        #200_000;
        bad_count++;
        print_verdict();
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    // random reads stay in 0..15 and random writes in 16..31, so no read
    // ever races a write still in the pipeline
    initial
    begin
        int n;
        int k;
        logic [AW-1:0] a;
        logic [7:0] s;
        repeat (6) @(posedge clk_sys);
        reset <= 1'h0;
        #1;
        `check(data_oe, 1'h0)
        for (n = 0; n < 32; n += 4)
            burst(AW'(n + 2), 1'h0);
        for (n = 0; n < 300; n++)
        begin
            k = $random(seed) & 7;
            a = AW'($random(seed));
            s = 8'($random(seed));
            if (k == 0)
                cmd(1'h1, a[0], a[1], a[4:2], a, s);
            else if (k == 1)
                cmd(1'h0, 1'h0, a[1], (a[4:2] == 3'h2) ? 3'h3 : a[4:2],
                    a, s);
            else if (k < 4 && sel)
                cmd(1'h0, 1'h1, a[1], a[4:2], a, s);
            else if (k < 6)
                cmd(1'h0, 1'h0, 1'h1, 3'h2, AW'(a[3:0]), s);
            else
                cmd(1'h0, 1'h0, 1'h0, 3'h2, AW'({1'h1, a[3:0]}), s);
        end
        for (n = 0; n < 2; n++)
            cmd(1'h0, 1'h0, 1'h1, 3'h3, '0, 8'hff);
        for (n = 0; n < 32; n += 4)
            burst(AW'(n + 2), 1'h1);
        for (n = 0; n < 4; n++)
            cmd(1'h0, 1'h0, 1'h1, 3'h6, '0, 8'hff);
        // the last read slot is taken at the edge of the last call, in a
        // race with this process: let the monitor run first
        repeat (2) @(posedge clk_sys);
        `check(exp_q.size(), 0)
        print_verdict();
    end
endmodule : sync_burst_sram_cmd_port_tb
